// >>> bench/i2cs_bus_master.sv
module i2cs_bus_master (
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      scl_low_o,
  output logic      sda_low_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    scl_low_o = 1'b0;
    sda_low_o = 1'b0;
  end
  // Bounded wait, so a stuck stretch ends in a failed check, not a hang
  task automatic rise();
    int n;
    n = 0;
    // Non-blocking drive, so a pin change never races the engine's clock edge
    scl_low_o <= 1'b0;
    #1;
    while (scl_i !== 1'b1 && n < 40000) begin
      #20;
      n++;
    end
  endtask
  // Sample at end of high phase: engine answers only after it sees the fall
  task automatic bit_io(input logic b, output logic r);
    #40 sda_low_o <= !b;
    #40 rise();
    #79 r = sda_i;
    scl_low_o <= 1'b1;
  endtask
  task automatic start();
    #40 sda_low_o <= 1'b0;
    #40 rise();
    #79 sda_low_o <= 1'b1;
    #80 scl_low_o <= 1'b1;
  endtask
  task automatic stop();
    #40 sda_low_o <= 1'b1;
    #40 rise();
    #79 sda_low_o <= 1'b0;
    #80;
  endtask
  task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic ao);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(a, ao);
  endtask
endmodule

// >>> bench/i2cs_engine_checker.sv
module i2cs_engine_checker (
  input logic       clock_i,
  input logic       rst_n_i,
  input logic       scl_oe_o,
  input logic       event_irq_enable_i,
  input logic       buffer_irq_enable_i,
  input logic       fast_speed_i,
  input logic [5:0] periph_freq_mhz_i,
  input logic       stop_request_i,
  input logic       sr1_read_i,
  input logic       sr2_read_i,
  input logic       cr1_write_i,
  input logic       dr_read_i,
  input logic       dr_write_i,
  input logic       master_mode_o,
  input logic       address_matched_o,
  input logic       direction_flag_o,
  input logic       transmit_empty_flag_o,
  input logic       receive_not_empty_flag_o,
  input logic       byte_transfer_finished_flag_o,
  input logic       stop_detected_flag_o,
  input logic       timing_ok_o,
  input logic       event_irq_o
);
  default clocking dc @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  a_irq_map:
    assert property (event_irq_o == (event_irq_enable_i && (address_matched_o || stop_detected_flag_o
      || byte_transfer_finished_flag_o || (buffer_irq_enable_i && (transmit_empty_flag_o || receive_not_empty_flag_o)))))
      else $error("event interrupt wrong");
  a_addr_clear:
    assert property (sr1_read_i ##1 sr2_read_i |=> !address_matched_o) else $error("match flag not cleared");
  a_addr_hold:
    assert property (address_matched_o && !sr2_read_i |=> address_matched_o) else $error("match flag lost");
  a_addr_stretch:
    assert property (address_matched_o && $past(address_matched_o, 3) |-> scl_oe_o) else $error("no stretch on match");
  a_stop_hold:
    assert property (stop_detected_flag_o && !cr1_write_i |=> stop_detected_flag_o) else $error("stop flag lost");
  a_stop_clear:
    assert property (sr1_read_i ##1 cr1_write_i |=> !stop_detected_flag_o) else $error("stop flag not cleared");
  a_rx_read:
    assert property (dr_read_i |=> !receive_not_empty_flag_o) else $error("rx flag not cleared");
  a_tx_load:
    assert property (dr_write_i |=> !transmit_empty_flag_o) else $error("tx flag not cleared");
  a_rx_full_stretch:
    assert property (byte_transfer_finished_flag_o [*3] ##0 !direction_flag_o |-> scl_oe_o)
      else $error("no stretch on full");
  a_speed_check:
    assert property ($past(rst_n_i) |-> timing_ok_o == ($past(fast_speed_i) ? $past(periph_freq_mhz_i) >= 6'h04
      : $past(periph_freq_mhz_i) >= 6'h02)) else $error("timing flag wrong");
  a_master_exit:
    assert property (stop_request_i && master_mode_o |-> ##[1:40] !master_mode_o) else $error("master mode kept");
  c_match: cover property ($rose(address_matched_o));
  c_full: cover property ($rose(byte_transfer_finished_flag_o));
  c_stop: cover property ($rose(stop_detected_flag_o));
endmodule

bind i2cs_engine i2cs_engine_checker u_i2cs_engine_checker (.*);

// >>> bench/tb_i2c_slave_mode_engine.sv
module tb_i2c_slave_mode_engine;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int ADDR = 0, RECEIVE_NOT_EMPTY_FLAG = 1, TRANSMIT_EMPTY_FLAG = 2, BYTE_TRANSFER_FINISHED_FLAG = 3, STOP_DETECTED_FLAG = 4, MSTR = 5, DIR = 6;
  localparam logic [4:0] SR1 = 5'h10, SR2 = 5'h08, CR1 = 5'h04, DRR = 5'h02, DRW = 5'h01;
  localparam logic [31:0] TMG = 32'h43440102;
  logic       clock_i = 1'b0;
  logic       rst_n_i = 1'b0;
  logic [9:0] own_p = 10'h000;
  logic [6:0] own_s = 7'h00;
  logic [7:0] wdat = 8'h00;
  logic [4:0] sw_p = 5'h00;
  logic       a10 = 0, dual = 0, gc = 0, ack_en = 1, evt_en = 1, buf_en = 1, fast = 0, start_req = 0, stop_req = 0;
  logic [5:0] freq = 6'h08;
  logic       receive_not_empty_flag_d = 1'b0;
  logic [7:0] exp_q[$];
  int         num_errors = 0, checked = 0;
  wire        scl_w, sda_w, m_scl, m_sda, scl_oe, scl_o, sda_oe, sda_o, which, tok, ev_irq, busy;
  wire [7:0]  rdata;
  wire [6:0]  fl;
  always #10 clock_i = ~clock_i;
  // Open drain with pull-ups: released lines read high
  assign scl_w = !((scl_oe && !scl_o) || m_scl);
  assign sda_w = !((sda_oe && !sda_o) || m_sda);
  i2cs_engine u_i2cs_engine (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .scl_i(scl_w), .scl_o(scl_o), .scl_oe_o(scl_oe), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe_o(sda_oe), .own_address_primary_i(own_p), .addr_10bit_i(a10),
    .own_address_secondary_i(own_s), .dual_address_enable_i(dual), .general_call_enable_i(gc),
    .ack_enable_i(ack_en), .event_irq_enable_i(evt_en), .buffer_irq_enable_i(buf_en), .fast_speed_i(fast),
    .periph_freq_mhz_i(freq), .start_request_i(start_req), .stop_request_i(stop_req), .sr1_read_i(sw_p[4]),
    .sr2_read_i(sw_p[3]), .cr1_write_i(sw_p[2]), .dr_read_i(sw_p[1]), .dr_write_i(sw_p[0]), .dr_wdata_i(wdat),
    .dr_rdata_o(rdata), .master_mode_o(fl[5]), .bus_busy_o(busy), .address_matched_o(fl[0]),
    .which_address_flag_o(which), .direction_flag_o(fl[6]), .transmit_empty_flag_o(fl[2]),
    .receive_not_empty_flag_o(fl[1]), .byte_transfer_finished_flag_o(fl[3]), .stop_detected_flag_o(fl[4]),
    .timing_ok_o(tok), .event_irq_o(ev_irq));
  i2cs_bus_master u_i2cs_bus_master (.scl_i(scl_w), .sda_i(sda_w), .scl_low_o(m_scl), .sda_low_o(m_sda));
  task automatic chk(input logic ok, input string m);
    checked++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task automatic sw(input logic [4:0] a, input logic [4:0] b);
    @(posedge clock_i) sw_p <= a;
    @(posedge clock_i) sw_p <= b;
    @(posedge clock_i) sw_p <= 5'h00;
    @(posedge clock_i);
  endtask
  task automatic wt(input int i, input logic v);
    int n;
    n = 0;
    while (fl[i] !== v && n < 20000) begin
      @(posedge clock_i);
      n++;
    end
    chk(fl[i] === v, "flag wait");
  endtask
  task automatic mx(input logic [7:0] d, input logic a, input logic e, output logic [7:0] q);
    logic ao;
    u_i2cs_bus_master.xfer(d, a, q, ao);
    chk(ao === e, "ack bit");
  endtask
  task automatic srv();
    wt(ADDR, 1'b1);
    chk(scl_oe === 1'b1 && ev_irq === evt_en, "match stretch");
    sw(SR1, SR2);
    chk(fl[ADDR] === 1'b0, "match clear");
  endtask
  task automatic fin();
    u_i2cs_bus_master.stop();
    wt(STOP_DETECTED_FLAG, 1'b1);
    chk(ev_irq === evt_en, "stop irq");
    sw(CR1, 5'h00);
    chk(fl[STOP_DETECTED_FLAG] === 1'b1, "stop kept");
    sw(SR1, CR1);
    chk(fl[STOP_DETECTED_FLAG] === 1'b0, "stop clear");
  endtask
  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Received bytes compared as the engine reports them
  always @(negedge clock_i) begin
    receive_not_empty_flag_d <= fl[RECEIVE_NOT_EMPTY_FLAG];
    if (fl[RECEIVE_NOT_EMPTY_FLAG] === 1'b1 && receive_not_empty_flag_d !== 1'b1) begin
      if (exp_q.size() == 0) chk(1'b0, "unexpected byte");
      else chk(rdata === exp_q.pop_front(), "rx byte");
    end
  end
  initial begin
    #1500000;
    num_errors++;
    tally_and_finish();
  end
  initial begin
    logic [6:0] a7;
    logic [7:0] d, rq;
    logic [9:0] p10;
    void'($urandom(72));
    repeat (5) @(posedge clock_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    chk(fl === 7'h00 && sda_oe === 1'b0 && scl_oe === 1'b0 && rdata === 8'h00, "reset");
    for (int k = 0; k < 4; k++) begin
      @(posedge clock_i) {fast, freq} <= TMG[8 * k +: 7];
      repeat (3) @(posedge clock_i);
      chk(tok === (k[0] ^ 1'b1), "timing");
    end
    a7 = 7'h08 + 7'($urandom % 100);
    @(posedge clock_i) {fast, freq} <= 7'h08;
    own_p <= {3'h0, a7};
    own_s <= a7 ^ 7'h01;
    $display("setup done");
    u_i2cs_bus_master.start();
    mx({a7, 1'b0}, 1'b1, 1'b0, rq);
    srv();
    for (int k = 0; k < 2; k++) begin
      d = 8'($urandom);
      exp_q.push_back(d);
      mx(d, 1'b1, 1'b0, rq);
      wt(RECEIVE_NOT_EMPTY_FLAG, 1'b1);
      sw(DRR, 5'h00);
    end
    d = 8'($urandom);
    exp_q.push_back(d);
    mx(d, 1'b1, 1'b0, rq);
    d = 8'($urandom);
    exp_q.push_back(d);
    fork
      mx(d, 1'b1, 1'b0, rq);
      begin
        wt(BYTE_TRANSFER_FINISHED_FLAG, 1'b1);
        chk(scl_oe === 1'b1, "stretch on full");
        sw(SR1, DRR);
      end
    join
    wt(RECEIVE_NOT_EMPTY_FLAG, 1'b1);
    chk(fl[BYTE_TRANSFER_FINISHED_FLAG] === 1'b0, "full cleared");
    sw(DRR, 5'h00);
    @(posedge clock_i) ack_en <= 1'b0;
    d = 8'($urandom);
    exp_q.push_back(d);
    mx(d, 1'b1, 1'b1, rq);
    wt(RECEIVE_NOT_EMPTY_FLAG, 1'b1);
    sw(DRR, 5'h00);
    @(posedge clock_i) ack_en <= 1'b1;
    fin();
    $display("write done");
    u_i2cs_bus_master.start();
    mx({a7 ^ 7'h40, 1'b0}, 1'b1, 1'b1, rq);
    mx(8'h55, 1'b1, 1'b1, rq);
    u_i2cs_bus_master.stop();
    repeat (10) @(posedge clock_i);
    chk(fl[ADDR] === 1'b0 && fl[STOP_DETECTED_FLAG] === 1'b0, "ignored");
    $display("mismatch done");
    for (int k = 0; k < 2; k++) begin
      @(posedge clock_i) {dual, gc, buf_en, evt_en} <= {2'h3, 2'(k)};
      u_i2cs_bus_master.start();
      mx(k == 1 ? 8'h00 : {a7 ^ 7'h01, 1'b0}, 1'b1, 1'b0, rq);
      wt(ADDR, 1'b1);
      chk(which === (k == 0), "which address");
      srv();
      fin();
    end
    @(posedge clock_i) {buf_en, evt_en} <= 2'h3;
    $display("dual done");
    u_i2cs_bus_master.start();
    mx({a7, 1'b1}, 1'b1, 1'b0, rq);
    wt(ADDR, 1'b1);
    chk(fl[DIR] === 1'b1 && fl[TRANSMIT_EMPTY_FLAG] === 1'b1, "tx ready");
    sw(SR1, SR2);
    chk(scl_oe === 1'b1, "stretch until loaded");
    d = 8'($urandom);
    @(posedge clock_i) wdat <= d;
    sw(DRW, 5'h00);
    mx(8'hFF, 1'b0, 1'b0, rq);
    chk(rq === d && fl[TRANSMIT_EMPTY_FLAG] === 1'b1, "tx byte");
    wt(BYTE_TRANSFER_FINISHED_FLAG, 1'b1);
    chk(scl_oe === 1'b1, "stretch on empty");
    d = 8'($urandom);
    @(posedge clock_i) wdat <= d;
    sw(SR1, DRW);
    mx(8'hFF, 1'b1, 1'b1, rq);
    chk(rq === d, "tx byte 2");
    fin();
    $display("read done");
    p10 = 10'($urandom);
    @(posedge clock_i) {a10, own_p} <= {1'b1, p10};
    u_i2cs_bus_master.start();
    mx({5'h1E, p10[9:8] ^ 2'h1, 1'b0}, 1'b1, 1'b1, rq);
    u_i2cs_bus_master.start();
    mx({5'h1E, p10[9:8], 1'b0}, 1'b1, 1'b0, rq);
    mx(p10[7:0], 1'b1, 1'b0, rq);
    srv();
    chk(fl[DIR] === 1'b0, "ten-bit receiver");
    u_i2cs_bus_master.start();
    mx({5'h1E, p10[9:8], 1'b1}, 1'b1, 1'b0, rq);
    wt(ADDR, 1'b1);
    chk(fl[DIR] === 1'b1, "ten-bit transmitter");
    sw(SR1, SR2);
    @(posedge clock_i) wdat <= ~d;
    sw(DRW, 5'h00);
    mx(8'hFF, 1'b1, 1'b1, rq);
    chk(rq === ~d, "ten-bit tx byte");
    fin();
    $display("ten-bit done");
    @(posedge clock_i) start_req <= 1'b1;
    @(posedge clock_i) start_req <= 1'b0;
    wt(MSTR, 1'b1);
    chk(sda_oe === 1'b1, "start drive");
    repeat (4) @(posedge clock_i);
    chk(busy === 1'b1, "bus busy");
    @(posedge clock_i) stop_req <= 1'b1;
    @(posedge clock_i) stop_req <= 1'b0;
    wt(MSTR, 1'b0);
    repeat (4) @(posedge clock_i);
    chk(busy === 1'b0, "bus free");
    chk(exp_q.size() == 0, "bytes left");
    $display("master done");
    tally_and_finish();
  end
endmodule

// >>> design/i2cs_engine.v
`include "i2cs_regs.vh"

// Summary of operation
// - Slave by default; master after own start
// - Handles standard and fast bus speeds
// - Flags input clock below speed minimum
// - Bytes shifted MSB first; 1/2 address bytes
// - Ninth clock carries the acknowledge bit
// - Compare primary, secondary, general call addresses
// - Ten-bit compare includes header 11110xx0
// - Mismatch ignored until next start
// - Header match acks, then awaits address
// - Full match acks, sets matched flag, event
// - Flag shows which own address matched
// - Ten-bit transmitter only after header 11110xx1
// - Direction flag shows receive or transmit
// - Transmitter stretches until flag cleared, data loaded
// - Master ack sets transmit-empty, buffer interrupt
// - Empty buffer sets finished flag, stretches
// - Receiver acks then sets receive-not-empty
// - Unread byte sets finished flag, stretches
// - Stop while addressed sets stop flag and event interrupt
// - Stop flag clears on status read, control write
module i2cs_engine (
  input  wire       clock_i,
  input  wire       rst_n_i,
  input  wire       scl_i,
  output wire       scl_o,
  output wire       scl_oe_o,
  input  wire       sda_i,
  output wire       sda_o,
  output wire       sda_oe_o,
  input  wire [9:0] own_address_primary_i,
  input  wire       addr_10bit_i,
  input  wire [6:0] own_address_secondary_i,
  input  wire       dual_address_enable_i,
  input  wire       general_call_enable_i,
  input  wire       ack_enable_i,
  input  wire       event_irq_enable_i,
  input  wire       buffer_irq_enable_i,
  input  wire       fast_speed_i,
  input  wire [5:0] periph_freq_mhz_i,
  input  wire       start_request_i,
  input  wire       stop_request_i,
  input  wire       sr1_read_i,
  input  wire       sr2_read_i,
  input  wire       cr1_write_i,
  input  wire       dr_read_i,
  input  wire       dr_write_i,
  input  wire [7:0] dr_wdata_i,
  output wire [7:0] dr_rdata_o,
  output wire       master_mode_o,
  output wire       bus_busy_o,
  output wire       address_matched_o,
  output wire       which_address_flag_o,
  output wire       direction_flag_o,
  output wire       transmit_empty_flag_o,
  output wire       receive_not_empty_flag_o,
  output wire       byte_transfer_finished_flag_o,
  output wire       stop_detected_flag_o,
  output wire       timing_ok_o,
  output wire       event_irq_o
);

  wire [1:0] pins_sync;
  reg        scl_d;
  reg        sda_d;
  reg  [2:0] state;
  reg  [1:0] ack_kind;
  reg  [3:0] bitcnt;
  reg  [7:0] shreg;
  reg  [7:0] data_register;
  reg        dr_full;
  reg        ack_drive;
  reg        tx_low;
  reg        stretch;
  reg        ack_seen;
  reg        addr10_ok;
  reg        slave_active;
  reg        sr1_last;
  reg        addr_flag;
  reg        which_address_flag;
  reg        direction_flag;
  reg        transmit_empty_flag;
  reg        receive_not_empty_flag;
  reg        byte_transfer_finished_flag;
  reg        stop_detected_flag;
  reg        busy;
  reg        master_mode;
  reg        m_sda_low;
  reg        timing_ok;

  i2cs_sync u_sync (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .async_i ({scl_i, sda_i}),
    .sync_o  (pins_sync)
  );

  wire scl_s    = pins_sync[1];
  wire sda_s    = pins_sync[0];
  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire start_det = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_det  = scl_s & scl_d & ~sda_d & sda_s;
  wire byte_done = scl_fall && (bitcnt == `I2CS_BITS_PER_BYTE);

  // Address decode of the byte just shifted in
  wire hdr_hit = addr_10bit_i && (shreg[`I2CS_HEADER_POS] == `I2CS_HEADER_VAL) &&
                 (shreg[2:1] == own_address_primary_i[9:8]);
  wire m_pri   = !addr_10bit_i && (shreg[7:1] == own_address_primary_i[6:0]);
  wire m_sec   = dual_address_enable_i && (shreg[7:1] == own_address_secondary_i);
  wire m_gc    = general_call_enable_i && (shreg == `I2CS_GEN_CALL);
  // Any other software access clears the sr1-read-first marker, breaking a clear sequence
  wire sw_other = sr2_read_i | cr1_write_i | dr_read_i | dr_write_i;

  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_d     <= 1'b1;
      sda_d     <= 1'b1;
      timing_ok <= 1'b0;
    end else begin
      scl_d     <= scl_s;
      sda_d     <= sda_s;
      timing_ok <= fast_speed_i ? (periph_freq_mhz_i >= `I2CS_MIN_MHZ_FAST) :
                                  (periph_freq_mhz_i >= `I2CS_MIN_MHZ_STD);
    end
  end

  // Master role: start while idle, back to slave on stop request only; the lost-arbitration branch never fires, as m_sda_low stays set in master mode
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      master_mode <= 1'b0;
      m_sda_low   <= 1'b0;
    end else if (!master_mode && start_request_i && !busy && scl_s && sda_s) begin
      master_mode <= 1'b1;
      m_sda_low   <= 1'b1;
    end else if (master_mode && stop_request_i) begin
      master_mode <= 1'b0;
      m_sda_low   <= 1'b0;
    end else if (master_mode && !m_sda_low && scl_s && !sda_s) begin
      master_mode <= 1'b0;
    end
  end

  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state                       <= `I2CS_ST_IDLE;
      ack_kind                    <= `I2CS_ACK_HEADER;
      bitcnt                      <= `I2CS_RST_COUNT;
      shreg                       <= `I2CS_RST_BYTE;
      data_register               <= `I2CS_RST_BYTE;
      dr_full                     <= 1'b0;
      ack_drive                   <= 1'b0;
      tx_low                      <= 1'b0;
      stretch                     <= 1'b0;
      ack_seen                    <= 1'b0;
      addr10_ok                   <= 1'b0;
      slave_active                <= 1'b0;
      sr1_last                    <= 1'b0;
      addr_flag                   <= 1'b0;
      which_address_flag          <= 1'b0;
      direction_flag              <= 1'b0;
      transmit_empty_flag         <= 1'b0;
      receive_not_empty_flag      <= 1'b0;
      byte_transfer_finished_flag <= 1'b0;
      stop_detected_flag          <= 1'b0;
      busy                        <= 1'b0;
    end else begin
      // Software side; hardware sets below come later and win
      if (sr1_read_i)
        sr1_last <= 1'b1;
      else if (sw_other)
        sr1_last <= 1'b0;
      if (sr2_read_i && sr1_last)
        addr_flag <= 1'b0;
      if (cr1_write_i && sr1_last)
        stop_detected_flag <= 1'b0;
      if ((dr_read_i || dr_write_i) && sr1_last)
        byte_transfer_finished_flag <= 1'b0;
      if (dr_read_i)
        receive_not_empty_flag <= 1'b0;
      if (dr_write_i) begin
        data_register       <= dr_wdata_i;
        dr_full             <= 1'b1;
        transmit_empty_flag <= 1'b0;
      end

      if (start_det)
        busy <= 1'b1;
      if (start_det && !master_mode) begin
        state     <= `I2CS_ST_ADDR1;
        bitcnt    <= `I2CS_RST_COUNT;
        ack_drive <= 1'b0;
        tx_low    <= 1'b0;
        stretch   <= 1'b0;
      end else if (stop_det) begin
        busy         <= 1'b0;
        state        <= `I2CS_ST_IDLE;
        ack_drive    <= 1'b0;
        tx_low       <= 1'b0;
        stretch      <= 1'b0;
        addr10_ok    <= 1'b0;
        slave_active <= 1'b0;
        if (slave_active)
          stop_detected_flag <= 1'b1;
      end else begin
        case (state)
          `I2CS_ST_ADDR1, `I2CS_ST_ADDR2, `I2CS_ST_RX: begin
            if (state == `I2CS_ST_RX && stretch && !addr_flag)
              stretch <= 1'b0;
            if (scl_rise) begin
              shreg  <= {shreg[6:0], sda_s};
              bitcnt <= bitcnt + 4'h1;
            end
            if (byte_done) begin
              bitcnt <= `I2CS_RST_COUNT;
              if (state == `I2CS_ST_RX) begin
                if (receive_not_empty_flag) begin
                  byte_transfer_finished_flag <= 1'b1;
                  stretch                     <= 1'b1;
                  state                       <= `I2CS_ST_WAIT;
                end else begin
                  ack_drive <= ack_enable_i;
                  ack_kind  <= `I2CS_ACK_DATA;
                  state     <= `I2CS_ST_ACK;
                end
              end else if (state == `I2CS_ST_ADDR2) begin
                if (shreg == own_address_primary_i[7:0]) begin
                  addr10_ok          <= 1'b1;
                  direction_flag     <= 1'b0;
                  which_address_flag <= 1'b0;
                  ack_drive          <= ack_enable_i;
                  ack_kind           <= `I2CS_ACK_ADDR_RX;
                  state              <= `I2CS_ST_ACK;
                end else begin
                  addr10_ok <= 1'b0;
                  state     <= `I2CS_ST_IDLE;
                end
              end else if (hdr_hit && !shreg[0]) begin
                ack_drive <= ack_enable_i;
                ack_kind  <= `I2CS_ACK_HEADER;
                state     <= `I2CS_ST_ACK;
              end else if (hdr_hit && addr10_ok) begin
                direction_flag <= 1'b1;
                ack_drive      <= ack_enable_i;
                ack_kind       <= `I2CS_ACK_ADDR_TX;
                state          <= `I2CS_ST_ACK;
              end else if (m_pri || m_sec || m_gc) begin
                direction_flag     <= shreg[0] && !m_gc;
                which_address_flag <= m_sec && !m_pri;
                ack_drive          <= ack_enable_i;
                ack_kind           <= (shreg[0] && !m_gc) ? `I2CS_ACK_ADDR_TX : `I2CS_ACK_ADDR_RX;
                state              <= `I2CS_ST_ACK;
              end else begin
                addr10_ok <= 1'b0;
                state     <= `I2CS_ST_IDLE;
              end
            end
          end
          `I2CS_ST_ACK: begin
            // Data line low only when acking; otherwise left released as a NACK
            if (scl_fall) begin
              ack_drive <= 1'b0;
              bitcnt    <= `I2CS_RST_COUNT;
              case (ack_kind)
                `I2CS_ACK_HEADER: state <= `I2CS_ST_ADDR2;
                `I2CS_ACK_ADDR_RX: begin
                  addr_flag    <= 1'b1;
                  slave_active <= 1'b1;
                  stretch      <= 1'b1;
                  state        <= `I2CS_ST_RX;
                end
                `I2CS_ACK_ADDR_TX: begin
                  addr_flag           <= 1'b1;
                  slave_active        <= 1'b1;
                  transmit_empty_flag <= !dr_full;
                  stretch             <= 1'b1;
                  state               <= `I2CS_ST_WAIT;
                end
                default: begin
                  data_register          <= shreg;
                  receive_not_empty_flag <= 1'b1;
                  state                  <= `I2CS_ST_RX;
                end
              endcase
            end
          end
          `I2CS_ST_WAIT: begin
            if (!direction_flag) begin
              // Clock held low until the finished flag and the unread byte are serviced
              if (!byte_transfer_finished_flag && !receive_not_empty_flag) begin
                stretch   <= 1'b0;
                ack_drive <= ack_enable_i;
                ack_kind  <= `I2CS_ACK_DATA;
                state     <= `I2CS_ST_ACK;
              end
            end else if (!addr_flag && dr_full && !byte_transfer_finished_flag) begin
              shreg   <= data_register;
              dr_full <= 1'b0;
              tx_low  <= !data_register[7];
              stretch <= 1'b0;
              bitcnt  <= `I2CS_RST_COUNT;
              state   <= `I2CS_ST_TX;
            end
          end
          `I2CS_ST_TX: begin
            if (scl_rise)
              bitcnt <= bitcnt + 4'h1;
            if (scl_fall) begin
              if (bitcnt == `I2CS_BITS_PER_BYTE) begin
                tx_low <= 1'b0;
                state  <= `I2CS_ST_TXACK;
              end else begin
                shreg  <= {shreg[6:0], 1'b0};
                tx_low <= !shreg[6];
              end
            end
          end
          `I2CS_ST_TXACK: begin
            if (scl_rise) begin
              ack_seen <= !sda_s;
              if (!sda_s)
                transmit_empty_flag <= !dr_full;
            end
            if (scl_fall) begin
              bitcnt <= `I2CS_RST_COUNT;
              if (ack_seen) begin
                state   <= `I2CS_ST_WAIT;
                stretch <= !dr_full;
                if (!dr_full)
                  byte_transfer_finished_flag <= 1'b1;
              end else begin
                state <= `I2CS_ST_IDLE;
              end
            end
          end
          default: begin
            ack_drive <= 1'b0;
            tx_low    <= 1'b0;
            stretch   <= 1'b0;
          end
        endcase
      end
    end
  end

  // Open-drain pins: only ever pulled low
  assign scl_o    = 1'b0;
  assign sda_o    = 1'b0;
  assign scl_oe_o = stretch;
  assign sda_oe_o = ack_drive | tx_low | m_sda_low;

  assign dr_rdata_o                    = data_register;
  assign master_mode_o                 = master_mode;
  assign bus_busy_o                    = busy;
  assign address_matched_o             = addr_flag;
  assign which_address_flag_o          = which_address_flag;
  assign direction_flag_o              = direction_flag;
  assign transmit_empty_flag_o         = transmit_empty_flag;
  assign receive_not_empty_flag_o      = receive_not_empty_flag;
  assign byte_transfer_finished_flag_o = byte_transfer_finished_flag;
  assign stop_detected_flag_o          = stop_detected_flag;
  assign timing_ok_o                   = timing_ok;
  assign event_irq_o = event_irq_enable_i &
                       (addr_flag | stop_detected_flag | byte_transfer_finished_flag |
                        (buffer_irq_enable_i & (transmit_empty_flag | receive_not_empty_flag)));

endmodule

// >>> design/i2cs_sync.v
module i2cs_sync (
  input  wire       clock_i,
  input  wire       rst_n_i,
  input  wire [1:0] async_i,
  output wire [1:0] sync_o
);

  reg [1:0] stage1;
  reg [1:0] stage2;

  // Idle bus level is high, so reset to high
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stage1 <= 2'h3;
      stage2 <= 2'h3;
    end else begin
      stage1 <= async_i;
      stage2 <= stage1;
    end
  end

  assign sync_o = stage2;

endmodule

// >>> include/i2cs_regs.vh
`ifndef I2CS_REGS_VH
`define I2CS_REGS_VH

// Slave engine states
`define I2CS_ST_IDLE     3'h0
`define I2CS_ST_ADDR1    3'h1
`define I2CS_ST_ADDR2    3'h2
`define I2CS_ST_ACK      3'h3
`define I2CS_ST_RX       3'h4
`define I2CS_ST_TX       3'h5
`define I2CS_ST_TXACK    3'h6
`define I2CS_ST_WAIT     3'h7

// What the pending acknowledge belongs to
`define I2CS_ACK_HEADER  2'h0
`define I2CS_ACK_ADDR_RX 2'h1
`define I2CS_ACK_ADDR_TX 2'h2
`define I2CS_ACK_DATA    2'h3

// Byte framing
`define I2CS_BITS_PER_BYTE 4'h8
`define I2CS_HEADER_POS    7:3
`define I2CS_HEADER_VAL    5'h1E
`define I2CS_GEN_CALL      8'h00

// Least programmed input clock per speed, in MHz
`define I2CS_MIN_MHZ_STD   6'h02
`define I2CS_MIN_MHZ_FAST  6'h04

// Reset values
`define I2CS_RST_BYTE      8'h00
`define I2CS_RST_COUNT     4'h0

`endif
